// [pkg/bf_pkg.sv]
// constants for the breaker failure supervision block
// assumes a 40 MHz clock and a 32-bit apb register port
package bf_pkg;

  // apb byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DLY_T1_1P = 8'h04;
  localparam logic [7:0] OFF_DLY_T1_3P = 8'h08;
  localparam logic [7:0] OFF_DLY_T2 = 8'h0c;
  localparam logic [7:0] OFF_DLY_T3 = 8'h10;
  localparam logic [7:0] OFF_DLY_TEND = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // control register fields
  localparam int CTRL_W = 8;
  localparam int CTRL_CONTACT_CHECK = 0;
  localparam int CTRL_RETRIP_1P = 1;
  localparam int CTRL_TWO_STAGE = 2;
  localparam int CTRL_SEPARATE_T1 = 3;
  localparam int CTRL_INT_BLOCK = 4;
  localparam int CTRL_RELEASE_ASSIGNED = 5;
  localparam int CTRL_SINGLE_POLE_OK = 6;
  localparam int CTRL_COMMON_AUX = 7;
  localparam logic [7:0] CTRL_RESET = 8'h41;

  // delay timer slots, values in ticks
  localparam int DLY_W = 16;
  localparam int NUM_DLY = 5;
  localparam int DLY_T1_1P = 0;
  localparam int DLY_T1_3P = 1;
  localparam int DLY_T2 = 2;
  localparam int DLY_T3 = 3;
  localparam int DLY_TEND = 4;
  localparam logic [15:0] RST_T1 = 16'h0064;
  localparam logic [15:0] RST_T2 = 16'h00c8;
  localparam logic [15:0] RST_T3 = 16'h0000;
  localparam logic [15:0] RST_TEND = 16'h0032;

  // status register fields
  localparam int ST_SINGLE_START = 0;
  localparam int ST_THREE_START = 3;
  localparam int ST_RETRIP = 4;
  localparam int ST_ADJACENT = 7;
  localparam int ST_END_FAULT = 8;
  localparam int ST_RUNNING = 9;

  // time base
  localparam int CLOCK_KHZ = 40000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = (TICK_US * CLOCK_KHZ) / 1000;
  localparam int SYNC_W = 17;

endpackage

// [design/bf_delay_timer.sv]
// one breaker failure delay stage counting the shared tick
// assumes run and tick come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none

module bf_delay_timer #(
  parameter int W = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic run,
  input wire logic [W-1:0] delay,
  output logic expired
);

  logic [W-1:0] cnt_q;
  logic active_q;

  always_ff @(posedge clock) begin
    if (!rst_n || !run) begin
      cnt_q <= '0;
      active_q <= 1'b0;
      expired <= 1'b0;
    end else if (!active_q) begin
      cnt_q <= delay;
      active_q <= 1'b1;
      expired <= (delay == '0);
    end else if (cnt_q != '0) begin
      if (tick) begin
        cnt_q <= cnt_q - 1'b1;
      end
      expired <= 1'b0;
    end else begin
      expired <= 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_timer_clear: assert property (!run |=> !expired)
    else $error("timer expired without its start condition");
  a_timer_load: assert property (run && !active_q |=> cnt_q == $past(delay))
    else $error("timer did not load its delay");

endmodule
`default_nettype wire

// [design/breaker_failure_initiation_timing.sv]
// breaker failure initiation, gating, delay stages and end fault detection
// assumes protection inputs are asynchronous pins and software uses apb
`timescale 1ns/10ps
`default_nettype none

module breaker_failure_initiation_timing #(
  parameter int TICK_CYCLES = bf_pkg::TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic phaseAStartInput,
  input wire logic phaseBStartInput,
  input wire logic phaseCStartInput,
  input wire logic commonStartInput,
  input wire logic startWithoutCurrentInput,
  input wire logic initiationReleaseInput,
  input wire logic failureBlockInput,
  input wire logic breakerInoperableInput,
  input wire logic [2:0] phaseCurrentFlow,
  input wire logic [1:0] plausibilityFlow,
  input wire logic [2:0] poleClosedContact,
  input wire logic seriesOpenChainBroken,
  output logic [2:0] singlePhaseStart,
  output logic threePhaseStart,
  output logic [2:0] retripPhase,
  output logic adjacentTrip,
  output logic endFaultTripOutput
);

  function automatic logic [2:0] count5(input logic [4:0] v);
    count5 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]} + {2'b00, v[4]};
  endfunction

  function automatic logic isReg(input logic [7:0] a, input logic [7:0] off);
    isReg = (a == off);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [bf_pkg::SYNC_W-1:0] rawIn;
  logic [bf_pkg::SYNC_W-1:0] meta_q;
  logic [bf_pkg::SYNC_W-1:0] sync_q;

  assign rawIn = {phaseCStartInput, phaseBStartInput, phaseAStartInput, commonStartInput,
                  startWithoutCurrentInput, initiationReleaseInput, failureBlockInput,
                  breakerInoperableInput, phaseCurrentFlow, plausibilityFlow,
                  poleClosedContact, seriesOpenChainBroken};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= rawIn;
      sync_q <= meta_q;
    end
  end

  wire [2:0] phaseStart = sync_q[16:14];
  wire commonStart = sync_q[13];
  wire startWoCurrent = sync_q[12];
  wire releaseIn = sync_q[11];
  wire blockIn = sync_q[10];
  wire inoperable = sync_q[9];
  wire [2:0] curFlow = sync_q[8:6];
  wire [1:0] plausFlow = sync_q[5:4];
  wire [2:0] poleClosed = sync_q[3:1];
  wire chainBroken = sync_q[0];

  //////////////////////////////////////////////////////////////////////////////
  // apb registers

  logic [bf_pkg::CTRL_W-1:0] ctrl_q;
  logic [bf_pkg::DLY_W-1:0] delay_q [bf_pkg::NUM_DLY];
  logic [31:0] status;

  wire access = psel && penable && !pready;
  wire selCtrl = isReg(paddr, bf_pkg::OFF_CTRL);
  wire selStatus = isReg(paddr, bf_pkg::OFF_STATUS);
  wire [7:0] dlyOff = paddr - bf_pkg::OFF_DLY_T1_1P;
  wire selDelay = (paddr >= bf_pkg::OFF_DLY_T1_1P) && (paddr <= bf_pkg::OFF_DLY_TEND)
                  && (paddr[1:0] == 2'b00);
  wire [2:0] dlyIdx = dlyOff[4:2];
  wire mapped = selCtrl || selStatus || selDelay;
  wire [31:0] readMux = selCtrl ? {24'h000000, ctrl_q} :
                        selDelay ? {16'h0000, delay_q[dlyIdx]} :
                        selStatus ? status : 32'h00000000;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access;
      pslverr <= access && !mapped;
      prdata <= (access && !pwrite) ? readMux : 32'h00000000;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_q <= bf_pkg::CTRL_RESET;
      delay_q[bf_pkg::DLY_T1_1P] <= bf_pkg::RST_T1;
      delay_q[bf_pkg::DLY_T1_3P] <= bf_pkg::RST_T1;
      delay_q[bf_pkg::DLY_T2] <= bf_pkg::RST_T2;
      delay_q[bf_pkg::DLY_T3] <= bf_pkg::RST_T3;
      delay_q[bf_pkg::DLY_TEND] <= bf_pkg::RST_TEND;
    end else if (psel && penable && pready && pwrite) begin
      if (selCtrl) begin
        ctrl_q <= pwdata[bf_pkg::CTRL_W-1:0];
      end
      if (selDelay) begin
        delay_q[dlyIdx] <= pwdata[bf_pkg::DLY_W-1:0];
      end
    end
  end

  wire contactCheck = ctrl_q[bf_pkg::CTRL_CONTACT_CHECK];
  wire retripSingle = ctrl_q[bf_pkg::CTRL_RETRIP_1P];
  wire twoStage = ctrl_q[bf_pkg::CTRL_TWO_STAGE];
  wire separateT1 = ctrl_q[bf_pkg::CTRL_SEPARATE_T1];
  wire internalBlock = ctrl_q[bf_pkg::CTRL_INT_BLOCK];
  wire releaseAssigned = ctrl_q[bf_pkg::CTRL_RELEASE_ASSIGNED];
  wire singlePoleOk = ctrl_q[bf_pkg::CTRL_SINGLE_POLE_OK];
  wire commonAux = ctrl_q[bf_pkg::CTRL_COMMON_AUX];

  //////////////////////////////////////////////////////////////////////////////
  // tick time base shared by all stages

  logic [15:0] tickCnt_q;
  logic tick_q;

  always_ff @(posedge clock) begin
    if (!rst_n || tickCnt_q == 16'(TICK_CYCLES - 1)) begin
      tickCnt_q <= 16'h0000;
    end else begin
      tickCnt_q <= tickCnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tickCnt_q == 16'(TICK_CYCLES - 1));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // current and contact criteria

  // two of five detectors must agree before any current counts
  wire plausOk = count5({curFlow, plausFlow}) >= 3'h2;
  wire [2:0] phaseCurrent = curFlow & {3{plausOk}};
  wire anyCurrent = |phaseCurrent;
  // a common contact only proves a single-pole opening once the open chain breaks
  wire [2:0] poleStillClosed = commonAux ? {3{!chainBroken}} : poleClosed;
  wire anyPoleClosed = |poleStillClosed;
  // current has priority; the contact is only a fallback when enabled
  wire [2:0] phaseCrit = phaseCurrent | (poleStillClosed & {3{contactCheck}});
  wire threeCrit = anyCurrent || (contactCheck && anyPoleClosed);

  //////////////////////////////////////////////////////////////////////////////
  // initiation

  wire multiPole = count5({2'b00, phaseStart}) >= 3'h2;
  wire gate = (!releaseAssigned || releaseIn) && !blockIn && !internalBlock;
  wire threeInit = multiPole || commonStart || startWoCurrent;
  // start without current also starts on the contacts alone, even with contact check off
  wire woCurrentStart = gate && startWoCurrent && anyPoleClosed;
  wire threeStartW = (gate && threeInit && threeCrit) || woCurrentStart;
  wire [2:0] loneStart;
  wire [2:0] singleStartW;

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_phase
      assign loneStart[p] = phaseStart[p] && ((phaseStart & ~(3'h1 << p)) == 3'h0);
      // per-phase starts dropped for three-pole-only breakers
      assign singleStartW[p] = gate && singlePoleOk && !threeInit && loneStart[p]
                               && phaseCrit[p];
    end
  endgenerate

  wire anySingle = |singleStartW;
  wire anyInit = anySingle || threeStartW;
  wire feederTrip = (|phaseStart) || commonStart;

  //////////////////////////////////////////////////////////////////////////////
  // delay stages

  logic [bf_pkg::NUM_DLY-1:0] runW;
  logic [bf_pkg::NUM_DLY-1:0] expW;

  assign runW[bf_pkg::DLY_T1_1P] = (twoStage || separateT1) && anySingle;
  assign runW[bf_pkg::DLY_T1_3P] = (twoStage || separateT1) && threeStartW;
  assign runW[bf_pkg::DLY_T2] = (twoStage || !separateT1) && anyInit;
  assign runW[bf_pkg::DLY_T3] = inoperable && feederTrip && !blockIn && !internalBlock;
  // end fault: current still flows with every pole reported open
  assign runW[bf_pkg::DLY_TEND] = anyInit && anyCurrent && !anyPoleClosed;

  generate
    for (p = 0; p < bf_pkg::NUM_DLY; p++) begin : g_timer
      bf_delay_timer #(
        .W(bf_pkg::DLY_W)
      ) u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .tick(tick_q),
        .run(runW[p]),
        .delay(delay_q[p]),
        .expired(expW[p])
      );
    end
  endgenerate

  wire t1Expired = expW[bf_pkg::DLY_T1_1P] || expW[bf_pkg::DLY_T1_3P];
  // retrip follows the original pole only after a single-pole feeder trip
  wire [2:0] retripW = !(twoStage && t1Expired) ? 3'h0 :
                       (retripSingle && anySingle) ? singleStartW : 3'h7;
  // adjacent trip is one three-pole command
  wire adjacentW = expW[bf_pkg::DLY_T2] || expW[bf_pkg::DLY_T3]
                   || (!twoStage && t1Expired);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      singlePhaseStart <= 3'h0;
      threePhaseStart <= 1'b0;
      retripPhase <= 3'h0;
      adjacentTrip <= 1'b0;
      endFaultTripOutput <= 1'b0;
    end else begin
      singlePhaseStart <= singleStartW;
      threePhaseStart <= threeStartW;
      retripPhase <= retripW;
      adjacentTrip <= adjacentW;
      endFaultTripOutput <= expW[bf_pkg::DLY_TEND];
    end
  end

  // adjacentTrip is meant to be wired to the remote intertrip input outside
  assign status = {{(32 - bf_pkg::ST_RUNNING - bf_pkg::NUM_DLY){1'b0}}, runW,
                   endFaultTripOutput, adjacentTrip, retripPhase, threePhaseStart,
                   singlePhaseStart};

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_suppressed;
    blockIn || internalBlock || (releaseAssigned && !releaseIn);
  endsequence

  sequence s_no_start;
    !(|singlePhaseStart) && !threePhaseStart;
  endsequence

  a_block_no_start: assert property (s_suppressed |=> s_no_start)
    else $error("start raised while blocked or unreleased");
  a_release_single: assert property (!releaseAssigned && !blockIn && !internalBlock
      && commonStart && anyCurrent |=> threePhaseStart)
    else $error("single channel start missing");
  a_multi_blocks_1p: assert property (multiPole |=> !(|singlePhaseStart))
    else $error("per-phase start during multi-pole trip");
  a_plaus_guard: assert property (!plausOk && !contactCheck |=> s_no_start)
    else $error("start without two current thresholds");
  a_lone_phase: assert property (singleStartW[0] |-> phaseStart == 3'h1 && phaseCrit[0])
    else $error("single start without lone start and criterion");
  a_contact_off: assert property (!contactCheck && !anyCurrent && !startWoCurrent
      |=> s_no_start)
    else $error("contact used while contact check off");
  a_inop_trip: assert property (expW[bf_pkg::DLY_T3] |=> adjacentTrip)
    else $error("inoperable timer expiry did not trip adjacent");
  a_end_fault: assert property (expW[bf_pkg::DLY_TEND] |=> endFaultTripOutput)
    else $error("end fault expiry not shown");
  a_retrip_3pole: assert property ($rose(|retripPhase) && !$past(retripSingle)
      |-> retripPhase == 3'h7)
    else $error("retrip not three-pole");
  a_tick_single: assert property (tick_q |=> !tick_q)
    else $error("tick longer than one cycle");
  a_single_stage_no_retrip: assert property (!twoStage |=> retripPhase == 3'h0)
    else $error("retrip issued in single stage");

endmodule
`default_nettype wire

// [verification/breaker_partner.sv]
// far-side model: feeder protection trips, breaker poles and contacts
// assumes the bench drives its controls just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module breaker_partner #(
  parameter int OPEN_CYC = 6
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] tripCmd,
  input wire logic [2:0] fault,
  input wire logic plausOn,
  input wire logic healthy,
  input wire logic endFault,
  input wire logic adjacentTrip,
  input wire logic endFaultTrip,
  output logic [2:0] startPin,
  output logic [2:0] currentFlow,
  output logic [1:0] plausFlow,
  output logic [2:0] poleClosed,
  output logic chainBroken,
  output logic remoteIntertrip
);
  int cnt [3];
  ////////////////////////////////////////////////////////////
  // a healthy pole opens some cycles after its trip, recloses on release
  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (!rst_n || !tripCmd[i]) begin
        cnt[i] <= 0;
        poleClosed[i] <= 1'b1;
      end else if (healthy && cnt[i] < OPEN_CYC) begin
        cnt[i] <= cnt[i] + 1;
      end else if (healthy) begin
        poleClosed[i] <= 1'b0;
      end
    end
  end
  assign startPin = tripCmd;
  // an end fault keeps feeding current through an open pole
  assign currentFlow = fault & (poleClosed | {3{endFault}});
  assign plausFlow = {2{plausOn && (currentFlow != 3'h0)}};
  assign chainBroken = !(&poleClosed);
  assign remoteIntertrip = adjacentTrip | endFaultTrip;
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the breaker failure block
// assumes the partner model drives the protection pins
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock = 0;
  logic rst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, ex;
  logic pready, pslverr, er;
  logic [2:0] trip = 3'h0;
  logic [2:0] fault = 3'h0;
  logic [2:0] sPin, pCur, pClosed, sps, retripPhase;
  logic plOn = 0, healthy = 0, endF = 0, swoc = 0, rel = 0, blk = 0, inop = 0, com = 0;
  logic [1:0] pPl;
  logic chain, tps, adjacentTrip, eft, remoteTrip;
  logic [7:0] ctrl = 8'h41;
  int err_total = 0, check_count = 0, cyc = 0, n, p;
  initial forever #12.5 clock = ~clock;
  ////////////////////////////////////////////////////////////
  // tick shortened to 4 cycles so delays of a few ticks stay short
  breaker_failure_initiation_timing #(.TICK_CYCLES(4)) dut_u (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .phaseAStartInput(sPin[0]),
    .phaseBStartInput(sPin[1]), .phaseCStartInput(sPin[2]), .commonStartInput(com),
    .startWithoutCurrentInput(swoc), .initiationReleaseInput(rel),
    .failureBlockInput(blk), .breakerInoperableInput(inop), .phaseCurrentFlow(pCur),
    .plausibilityFlow(pPl), .poleClosedContact(pClosed), .seriesOpenChainBroken(chain),
    .singlePhaseStart(sps), .threePhaseStart(tps), .retripPhase(retripPhase),
    .adjacentTrip(adjacentTrip), .endFaultTripOutput(eft));
  breaker_partner pt_u (.clock(clock), .rst_n(rst_n), .tripCmd(trip), .fault(fault),
    .plausOn(plOn), .healthy(healthy), .endFault(endF), .adjacentTrip(adjacentTrip),
    .endFaultTrip(eft), .startPin(sPin), .currentFlow(pCur), .plausFlow(pPl),
    .poleClosed(pClosed), .chainBroken(chain), .remoteIntertrip(remoteTrip));
  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // entered just after a rising edge; holds the request until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // only the bench timeout ends a wait for pready
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // behavioural start model built from partner pin levels
  function automatic logic [3:0] expStart();
    logic [2:0] cf, cl, crit;
    logic en, multi;
    cf = ($countones({pPl, pCur}) >= 2) ? pCur : 3'h0;
    cl = ctrl[7] ? {3{!chain}} : pClosed;
    crit = cf | (ctrl[0] ? cl : 3'h0);
    en = !blk && !ctrl[4] && (!ctrl[5] || rel);
    multi = ($countones(trip) > 1) || com;
    expStart[3] = en && (((multi || swoc) && |crit) || (swoc && |cl));
    expStart[2:0] = (en && !multi && !swoc && ctrl[6]) ? trip & crit : 3'h0;
  endfunction
  function automatic logic pick(input int s);
    case (s)
      0: pick = adjacentTrip;
      1: pick = |retripPhase;
      default: pick = eft;
    endcase
  endfunction
  task automatic waitFor(input int s);
    n = 0;
    while (pick(s) !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic idle();
    {trip, fault, plOn, healthy, endF, inop, swoc, rel, blk} <= '0;
    repeat (12) @(posedge clock);
  endtask
  task automatic go(input logic [7:0] c, input logic [2:0] tr, input logic [2:0] f,
                    input logic pl, input logic b, input logic r, input logic s);
    ctrl = c;
    apb(1'b1, bf_pkg::OFF_CTRL, {24'h0, c});
    {trip, fault, plOn, blk, rel, swoc} <= {tr, f, pl, b, r, s};
  endtask
  task automatic look(input logic [7:0] c, input logic [2:0] tr, input logic [2:0] f,
                      input logic pl, input logic b, input logic r, input logic s);
    go(c, tr, f, pl, b, r, s);
    repeat (16) @(posedge clock);
    chk({28'h0, tps, sps}, {28'h0, expStart()});
  endtask
  task automatic stage(input logic [7:0] c, input logic [2:0] tr, input logic [2:0] e);
    go(c, tr, 3'h7, 1'b1, 1'b0, 1'b0, 1'b0);
    waitFor(1);
    chk(retripPhase, e);
    waitFor(0);
    chk(adjacentTrip, 1'b1);
    idle();
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h2ce22000));
    p = $urandom % 3;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rdchk(bf_pkg::OFF_CTRL, 32'h41);
    rdchk(bf_pkg::OFF_DLY_T1_1P, 32'h64);
    rdchk(bf_pkg::OFF_DLY_T1_3P, 32'h64);
    rdchk(bf_pkg::OFF_DLY_T2, 32'hc8);
    rdchk(bf_pkg::OFF_DLY_T3, 32'h0);
    rdchk(bf_pkg::OFF_DLY_TEND, 32'h32);
    rdchk(8'h1c, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, bf_pkg::OFF_DLY_T2, 32'h5);
    apb(1'b1, bf_pkg::OFF_DLY_T1_1P, 32'h2);
    apb(1'b1, bf_pkg::OFF_DLY_T1_3P, 32'h6);
    apb(1'b1, bf_pkg::OFF_DLY_TEND, 32'h4);
    look(8'h41, 3'h1 << p, 3'h7, 1, 0, 0, 0);
    look(8'h41, 3'h3, 3'h7, 1, 0, 0, 0);
    look(8'h41, 3'h1 << p, 3'h7, 1, 1, 0, 0);
    look(8'h51, 3'h1 << p, 3'h7, 1, 0, 0, 0);
    look(8'h61, 3'h1 << p, 3'h7, 1, 0, 0, 0);
    look(8'h61, 3'h1 << p, 3'h7, 1, 0, 1, 0);
    look(8'h40, 3'h1, 3'h1, 0, 0, 0, 0);
    look(8'h41, 3'h1, 3'h0, 0, 0, 0, 0);
    look(8'h41, 3'h0, 3'h0, 0, 0, 0, 1);
    com <= 1'b1;
    look(8'h41, 3'h0, 3'h7, 1, 0, 0, 0);
    com <= 1'b0;
    look(8'h01, 3'h1 << p, 3'h7, 1, 0, 0, 0);
    // common contact: the opened pole breaks the chain and drops the criterion
    healthy <= 1'b1;
    look(8'hc1, 3'h1 << p, 3'h0, 0, 0, 0, 0);
    idle();
    go(8'h41, 3'h1 << p, 3'h7, 1, 0, 0, 0);
    waitFor(0);
    chk(n >= 20 && n <= 32, 1);
    chk(remoteTrip, 1'b1);
    ex = (32'h1 << bf_pkg::ST_ADJACENT) | (32'h1 << (bf_pkg::ST_SINGLE_START + p));
    ex = ex | (32'h1 << (bf_pkg::ST_RUNNING + bf_pkg::DLY_T2));
    rdchk(bf_pkg::OFF_STATUS, ex);
    trip <= 3'h0;
    repeat (8) @(posedge clock);
    chk(adjacentTrip, 1'b0);
    healthy <= 1'b1;
    trip <= 3'h1 << p;
    repeat (40) @(posedge clock);
    chk(adjacentTrip, 1'b0);
    idle();
    stage(8'h47, 3'h1 << p, 3'h1 << p);
    stage(8'h45, 3'h1 << p, 3'h7);
    stage(8'h47, 3'h3, 3'h7);
    go(8'h49, 3'h1 << p, 3'h7, 1, 0, 0, 0);
    waitFor(0);
    chk(n <= 20, 1);
    idle();
    go(8'h49, 3'h3, 3'h7, 1, 0, 0, 0);
    waitFor(0);
    chk(n >= 22 && n <= 36, 1);
    idle();
    inop <= 1'b1;
    go(8'h41, 3'h1 << p, 3'h7, 1, 0, 0, 0);
    waitFor(0);
    chk(n <= 10, 1);
    idle();
    {healthy, endF} <= 2'b11;
    go(8'h41, 3'h7, 3'h7, 1, 0, 0, 0);
    waitFor(2);
    chk(eft, 1'b1);
    chk(remoteTrip, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
